// File: logic/bus_error_log_and_report.sv
// error log and SMI/SERR report register bank of the memory hub, APB slave
// Behaviour
// (R01) hub A SMI enable bit 6 raises SMI while target abort logged first or next.
// (R02) hub A SMI enable bit 4 raises SMI while data parity logged first or next.
// (R03) hub A SMI enable bit 0 raises SMI while address/command parity logged.
// (R04) hub A SERR enable bit 6 asserts SERR while target abort logged.
// (R05) hub A SERR enable bit 4 asserts SERR while data parity logged.
// (R06) hub A SERR enable bit 0 asserts SERR while address/command parity logged.
// (R07) software enables at most one message type per error flag.
// (R08) system bus first-error holds only the first error until software clears it.
// (R09) system bus next-error collects every later error, several bits at once.
// (R10) flags clear only by writing one to them; zero leaves them alone.
// (R11) bit 7 sets on falling edge of the bus init pin.
// (R12) bit 6 sets on falling edge of the bus error pin.
// (R13) bit 5 sets on a locked access outside main memory.
// (R14) bit 4 sets on an address above top of memory and above 4 GB.
// (R15) bit 3 sets on a system bus data parity error.
// (R16) bit 2 sets on an address strobe glitch.
// (R17) bit 1 sets on a data strobe glitch.
// (R18) bit 0 sets on an address or request parity error.
// (R19) hub A log bits: 6 target abort, 4 data parity, 0 address/command parity.
// (R20) reserved bits read zero and ignore writes.
// (R21) an error sets first-error only if empty, otherwise only next-error.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module bus_error_log_and_report
   import err_log_pkg::*;
(
   // clock, reset, enable
   input  wire logic                 core_clk,
   input  wire logic                 srst,
   input  wire logic                 ce,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [PADDR_W-1:0]   paddr,
   input  wire logic [DATA_W-1:0]    pwdata,
   output logic                      pready,
   output logic      [DATA_W-1:0]    prdata,
   output logic                      pslverr,
   // hub link A detectors, one-cycle pulses
   input  wire logic                 hub_a_target_abort,
   input  wire logic                 hub_a_data_parity,
   input  wire logic                 hub_a_addr_cmd_parity,
   // system bus pins, low when asserted
   input  wire logic                 bus_init_signal_n,
   input  wire logic                 bus_error_signal_n,
   // system bus detectors, one-cycle pulses
   input  wire logic                 lock_req_valid,
   input  wire logic                 lock_hits_memory,
   input  wire logic                 req_addr_valid,
   input  wire logic [SB_ADDR_W-1:0] req_addr,
   input  wire logic [SB_ADDR_W-1:0] last_row_boundary,
   input  wire logic                 bus_data_parity_err,
   input  wire logic                 address_strobe_glitch,
   input  wire logic                 data_strobe_glitch,
   input  wire logic                 request_parity_err,
   // messages, levels
   output logic                      smi,
   output logic                      serr
);

   typedef struct packed {
      logic [REG_W-1:0]  hub_a_smi_enable;
      logic [REG_W-1:0]  hub_a_serr_enable;
      logic [DATA_W-1:0] rdata;
      logic              armed;
      logic              smi;
      logic              serr;
   } bank_state_t;

   bank_state_t       state;
   bank_state_t       next_state;

   logic              wr_fire;
   logic              hit;
   logic [REG_W-1:0]  wbyte;
   logic [REG_W-1:0]  rd_mux;
   logic [REG_W-1:0]  hub_detect;
   logic [REG_W-1:0]  hub_first_clear;
   logic [REG_W-1:0]  hub_next_clear;
   logic [REG_W-1:0]  sys_detect;
   logic [REG_W-1:0]  sys_first_clear;
   logic [REG_W-1:0]  sys_next_clear;
   logic [REG_W-1:0]  hub_a_first_error;
   logic [REG_W-1:0]  hub_a_next_error;
   logic [REG_W-1:0]  system_bus_first_error;
   logic [REG_W-1:0]  system_bus_next_error;
   logic [REG_W-1:0]  hub_logged;
   logic [1:0]        pin_fell;
   logic              over_top;

   // bus pins cross into core_clk before any edge logic reads them
   pin_fall_detect #(
      .N (2)
   ) u_pins (
      .core_clk (core_clk),
      .srst     (srst),
      .ce       (ce),
      .pin_n    ({bus_init_signal_n, bus_error_signal_n}),
      .fell     (pin_fell)
   );

   // hub link A log
   err_capture #(
      .MASK (HUB_A_MASK)
   ) u_hub_a_log (
      .core_clk    (core_clk),
      .srst        (srst),
      .ce          (ce),
      .detect      (hub_detect),
      .first_clear (hub_first_clear),
      .next_clear  (hub_next_clear),
      .first_log   (hub_a_first_error),
      .next_log    (hub_a_next_error)
   );

   // system bus log
   err_capture #(
      .MASK (SYS_MASK)
   ) u_sys_log (
      .core_clk    (core_clk),
      .srst        (srst),
      .ce          (ce),
      .detect      (sys_detect),
      .first_clear (sys_first_clear),
      .next_clear  (sys_next_clear),
      .first_log   (system_bus_first_error),
      .next_log    (system_bus_next_error)
   );

   // error event gathering
   always_comb begin
      hub_detect = REG_RESET;
      hub_detect[HUB_TARGET_ABORT_BIT] = hub_a_target_abort;                   // [R19]
      hub_detect[HUB_DATA_PARITY_BIT]  = hub_a_data_parity;                    // [R19]
      hub_detect[HUB_ADDR_CMD_BIT]     = hub_a_addr_cmd_parity;                // [R19]

      // both limits must be passed; a low top of memory alone does not flag
      over_top = req_addr_valid && (req_addr > last_row_boundary)
                 && (req_addr > FOUR_GB);                                      // [R14]

      sys_detect = REG_RESET;
      sys_detect[SYS_BUS_INIT_BIT]      = pin_fell[1];                         // [R11]
      sys_detect[SYS_BUS_ERROR_BIT]     = pin_fell[0];                         // [R12]
      sys_detect[SYS_LOCK_OUTSIDE_BIT]  = lock_req_valid & ~lock_hits_memory;  // [R13]
      sys_detect[SYS_ADDR_OVER_TOP_BIT] = over_top;                            // [R14]
      sys_detect[SYS_DATA_PARITY_BIT]   = bus_data_parity_err;                 // [R15]
      sys_detect[SYS_ADDR_GLITCH_BIT]   = address_strobe_glitch;               // [R16]
      sys_detect[SYS_DATA_GLITCH_BIT]   = data_strobe_glitch;                  // [R17]
      sys_detect[SYS_REQ_PARITY_BIT]    = request_parity_err;                  // [R18]
   end

   // APB decode
   always_comb begin
      pready  = psel & penable & ce & state.armed;
      wr_fire = pready & pwrite;
      wbyte   = pwdata[REG_W-1:0];
      hit     = 1'b1;
      rd_mux  = REG_RESET;
      unique case (paddr)
         ADDR_HUB_A_FIRST_ERROR: rd_mux = hub_a_first_error;
         ADDR_HUB_A_NEXT_ERROR:  rd_mux = hub_a_next_error;
         ADDR_HUB_A_SMI_ENABLE:  rd_mux = state.hub_a_smi_enable;
         ADDR_HUB_A_SERR_ENABLE: rd_mux = state.hub_a_serr_enable;
         ADDR_SYS_FIRST_ERROR:   rd_mux = system_bus_first_error;
         ADDR_SYS_NEXT_ERROR:    rd_mux = system_bus_next_error;
         default:                hit = 1'b0;
      endcase
      pslverr = pready & ~hit;

      // write-one-to-clear strobes, one per log register so a clear never reaches the other half
      hub_first_clear = REG_RESET;
      hub_next_clear  = REG_RESET;
      sys_first_clear = REG_RESET;
      sys_next_clear  = REG_RESET;
      if (wr_fire && paddr == ADDR_HUB_A_FIRST_ERROR) begin
         hub_first_clear = wbyte;                                              // [R10]
      end
      if (wr_fire && paddr == ADDR_HUB_A_NEXT_ERROR) begin
         hub_next_clear = wbyte;                                               // [R10]
      end
      if (wr_fire && paddr == ADDR_SYS_FIRST_ERROR) begin
         sys_first_clear = wbyte;                                              // [R10]
      end
      if (wr_fire && paddr == ADDR_SYS_NEXT_ERROR) begin
         sys_next_clear = wbyte;                                               // [R10]
      end
   end

   // register bank and message generation
   always_comb begin
      next_state = state;

      // read data is sampled one edge before completion so prdata comes from a flop
      next_state.armed = psel & ~pready;
      if (psel && !pready) begin
         next_state.rdata = {{(DATA_W-REG_W){1'b0}}, rd_mux};
      end

      if (wr_fire && paddr == ADDR_HUB_A_SMI_ENABLE) begin
         next_state.hub_a_smi_enable = wbyte & HUB_A_MASK;                     // [R20]
      end
      if (wr_fire && paddr == ADDR_HUB_A_SERR_ENABLE) begin
         next_state.hub_a_serr_enable = wbyte & HUB_A_MASK;                    // [R20]
      end

      // messages follow the logged flags, not the raw events, so they hold until cleared;
      // enabling both types on one flag is not checked here
      hub_logged = hub_a_first_error | hub_a_next_error;
      next_state.smi =
           (state.hub_a_smi_enable[HUB_TARGET_ABORT_BIT] & hub_logged[HUB_TARGET_ABORT_BIT]) // [R01]
         | (state.hub_a_smi_enable[HUB_DATA_PARITY_BIT]  & hub_logged[HUB_DATA_PARITY_BIT])  // [R02]
         | (state.hub_a_smi_enable[HUB_ADDR_CMD_BIT]     & hub_logged[HUB_ADDR_CMD_BIT]);    // [R03]
      next_state.serr =
           (state.hub_a_serr_enable[HUB_TARGET_ABORT_BIT] & hub_logged[HUB_TARGET_ABORT_BIT]) // [R04]
         | (state.hub_a_serr_enable[HUB_DATA_PARITY_BIT]  & hub_logged[HUB_DATA_PARITY_BIT])  // [R05]
         | (state.hub_a_serr_enable[HUB_ADDR_CMD_BIT]     & hub_logged[HUB_ADDR_CMD_BIT]);    // [R06]
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '{hub_a_smi_enable:  REG_RESET,
                    hub_a_serr_enable: REG_RESET,
                    rdata:             DATA_ZERO,
                    armed:             1'b0,
                    smi:               1'b0,
                    serr:              1'b0};
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign prdata = state.rdata;
   assign smi    = state.smi;
   assign serr   = state.serr;

endmodule

// File: logic/err_capture.sv
// first-error / next-error capture pair with write-one-to-clear
`timescale 1ns/100ps
module err_capture
   import err_log_pkg::*;
#(
   parameter logic [REG_W-1:0] MASK = SYS_MASK
) (
   // clock, reset, enable
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             ce,
   // error events and software clears, one vector per register
   input  wire logic [REG_W-1:0] detect,
   input  wire logic [REG_W-1:0] first_clear,
   input  wire logic [REG_W-1:0] next_clear,
   // logged flags
   output logic      [REG_W-1:0] first_log,
   output logic      [REG_W-1:0] next_log
);

   typedef struct packed {
      logic [REG_W-1:0] first_log;
      logic [REG_W-1:0] next_log;
   } cap_state_t;

   cap_state_t       state;
   cap_state_t       next_state;
   logic [REG_W-1:0] det;
   logic [REG_W-1:0] pick;
   logic             first_empty;

   always_comb begin
      det  = detect & MASK;
      pick = REG_RESET;
      // simultaneous errors: highest bit is logged as first, the rest as next
      for (int i = 0; i < REG_W; i++) begin
         if (det[i]) begin
            pick = REG_RESET;
            pick[i] = 1'b1;
         end
      end
      first_empty = (state.first_log == REG_RESET);
      next_state = state;
      next_state.first_log = state.first_log & ~first_clear & MASK;            // [R10] [R20]
      next_state.next_log  = state.next_log & ~next_clear & MASK;              // [R10] [R20]
      if (first_empty) begin
         next_state.first_log = next_state.first_log | pick;                   // [R08] [R21]
         next_state.next_log  = next_state.next_log | (det & ~pick);           // [R09]
      end else begin
         // clear in the same cycle still counts as occupied: the event is kept in next
         next_state.next_log  = next_state.next_log | det;                     // [R08] [R09] [R21]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '{first_log: REG_RESET, next_log: REG_RESET};
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign first_log = state.first_log;
   assign next_log  = state.next_log;

endmodule

// File: logic/err_log_pkg.sv
// constants shared by the bus error log and report block
package err_log_pkg;

   // widths
   localparam int REG_W     = 8;
   localparam int DATA_W    = 32;
   localparam int PADDR_W   = 12;
   localparam int SB_ADDR_W = 36;

   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_HUB_A_FIRST_ERROR = 8'h50;
   localparam logic [7:0] IDX_HUB_A_NEXT_ERROR  = 8'h52;
   localparam logic [7:0] IDX_HUB_A_SMI_ENABLE  = 8'h5A;
   localparam logic [7:0] IDX_HUB_A_SERR_ENABLE = 8'h5C;
   localparam logic [7:0] IDX_SYS_FIRST_ERROR   = 8'h60;
   localparam logic [7:0] IDX_SYS_NEXT_ERROR    = 8'h62;

   localparam logic [PADDR_W-1:0] ADDR_HUB_A_FIRST_ERROR = {2'h0, IDX_HUB_A_FIRST_ERROR, 2'h0};
   localparam logic [PADDR_W-1:0] ADDR_HUB_A_NEXT_ERROR  = {2'h0, IDX_HUB_A_NEXT_ERROR, 2'h0};
   localparam logic [PADDR_W-1:0] ADDR_HUB_A_SMI_ENABLE  = {2'h0, IDX_HUB_A_SMI_ENABLE, 2'h0};
   localparam logic [PADDR_W-1:0] ADDR_HUB_A_SERR_ENABLE = {2'h0, IDX_HUB_A_SERR_ENABLE, 2'h0};
   localparam logic [PADDR_W-1:0] ADDR_SYS_FIRST_ERROR   = {2'h0, IDX_SYS_FIRST_ERROR, 2'h0};
   localparam logic [PADDR_W-1:0] ADDR_SYS_NEXT_ERROR    = {2'h0, IDX_SYS_NEXT_ERROR, 2'h0};

   // hub link A field positions
   localparam int HUB_TARGET_ABORT_BIT = 6;
   localparam int HUB_DATA_PARITY_BIT  = 4;
   localparam int HUB_ADDR_CMD_BIT     = 0;

   // system bus field positions
   localparam int SYS_BUS_INIT_BIT      = 7;
   localparam int SYS_BUS_ERROR_BIT     = 6;
   localparam int SYS_LOCK_OUTSIDE_BIT  = 5;
   localparam int SYS_ADDR_OVER_TOP_BIT = 4;
   localparam int SYS_DATA_PARITY_BIT   = 3;
   localparam int SYS_ADDR_GLITCH_BIT   = 2;
   localparam int SYS_DATA_GLITCH_BIT   = 1;
   localparam int SYS_REQ_PARITY_BIT    = 0;

   // implemented bits and reset values
   localparam logic [REG_W-1:0] HUB_A_MASK = 8'h51;
   localparam logic [REG_W-1:0] SYS_MASK   = 8'hFF;
   localparam logic [REG_W-1:0] REG_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   // 4 GB line on the system bus address
   localparam logic [SB_ADDR_W-1:0] FOUR_GB = 36'h1_0000_0000;

endpackage

// File: logic/pin_fall_detect.sv
// two-flop synchroniser and falling-edge pulse for active-low bus pins
`timescale 1ns/100ps
module pin_fall_detect
   import err_log_pkg::*;
#(
   parameter int N = 2
) (
   // clock, reset, enable
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire logic         ce,
   // raw pins, electrically low when asserted
   input  wire logic [N-1:0] pin_n,
   // one-cycle pulse per high-to-low transition
   output logic      [N-1:0] fell
);

   typedef struct packed {
      logic [N-1:0] stage1;
      logic [N-1:0] stage2;
      logic [N-1:0] prev;
      logic [N-1:0] fell;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   always_comb begin
      next_state = state;
      next_state.stage1 = pin_n;
      next_state.stage2 = state.stage1;
      next_state.prev   = state.stage2;
      // pins idle high, so reset to ones avoids a false edge at release
      next_state.fell   = state.prev & ~state.stage2;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '{stage1: '1, stage2: '1, prev: '1, fell: '0};
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign fell = state.fell;

endmodule

// File: test/bus_error_log_sva.sv
// port checker for the bus error log and report block
`timescale 1ns/100ps
module bus_error_log_sva
   import err_log_pkg::*;
(
   // clock, reset, enable
   input wire logic               core_clk,
   input wire logic               srst,
   input wire logic               ce,
   // APB
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0]  prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // hub link A events and messages
   input wire logic               hub_a_target_abort,
   input wire logic               hub_a_data_parity,
   input wire logic               hub_a_addr_cmd_parity,
   input wire logic               smi,
   input wire logic               serr
);
   logic mapped;
   logic wr;
   logic cause;
   assign mapped = paddr inside {ADDR_HUB_A_FIRST_ERROR, ADDR_HUB_A_NEXT_ERROR, ADDR_HUB_A_SMI_ENABLE,
                                 ADDR_HUB_A_SERR_ENABLE, ADDR_SYS_FIRST_ERROR, ADDR_SYS_NEXT_ERROR};
   assign wr = psel && penable && pwrite && pready;
   // a message may only start from a fresh event or from software enabling it
   assign cause = wr || hub_a_target_abort || hub_a_data_parity || hub_a_addr_cmd_parity;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_setup; psel && !penable && ce; endsequence
   sequence s_access; psel && penable; endsequence
   property p_zero_wait; s_setup ##1 s_access |-> pready; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("access phase not answered at once");
   property p_ready_gate; pready |-> psel && penable && ce; endproperty
   a_ready_gate: assert property (p_ready_gate) else $error("pready outside an access phase");
   property p_err_map; pslverr == (pready && !mapped); endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr does not follow the address map");
   property p_rd_zero; pready && !mapped && !pwrite |-> prdata == DATA_ZERO; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
   property p_upper_zero; prdata[31:8] == 24'h000000; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
   property p_smi_rise; $rose(smi) |-> $past(cause, 1) || $past(cause, 2) || $past(cause, 3); endproperty
   a_smi_rise: assert property (p_smi_rise) else $error("smi rose without cause");
   property p_serr_rise; $rose(serr) |-> $past(cause, 1) || $past(cause, 2) || $past(cause, 3); endproperty
   a_serr_rise: assert property (p_serr_rise) else $error("serr rose without cause");
   property p_smi_fall; $fell(smi) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3) || $past(srst, 1); endproperty
   a_smi_fall: assert property (p_smi_fall) else $error("smi fell without a write");
   property p_serr_fall; $fell(serr) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3) || $past(srst, 1); endproperty
   a_serr_fall: assert property (p_serr_fall) else $error("serr fell without a write");
   property p_reset_quiet; $fell(srst) |-> !smi && !serr; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("message active after reset");
endmodule

// File: test/err_source.sv
// model of the hub link A and system bus error detectors
`timescale 1ns/100ps
module err_source
   import err_log_pkg::*;
(
   // clock and command
   input  wire logic                 core_clk,
   input  wire logic                 fire,
   input  wire logic [3:0]           code,
   // one-cycle detector pulses, one bit per code
   output logic      [15:0]          p,
   // active-low pins and qualified requests
   output logic                      bus_init_signal_n,
   output logic                      bus_error_signal_n,
   output logic                      lock_req_valid,
   output logic                      lock_hits_memory,
   output logic                      req_addr_valid,
   output logic      [SB_ADDR_W-1:0] req_addr,
   output logic      [SB_ADDR_W-1:0] last_row_boundary
);
   logic [2:0] hold_i = 3'h0;
   logic [2:0] hold_e = 3'h0;
   initial p = 16'h0000;
   always @(posedge core_clk) begin
      p <= fire ? (16'h0001 << code) : 16'h0000;
      // pins stay low long enough for the two-flop synchroniser
      hold_i <= (fire && code == 4'h7) ? 3'h6 : (hold_i != 3'h0) ? hold_i - 3'h1 : 3'h0;
      hold_e <= (fire && code == 4'h6) ? 3'h6 : (hold_e != 3'h0) ? hold_e - 3'h1 : 3'h0;
   end
   assign bus_init_signal_n = (hold_i == 3'h0);
   assign bus_error_signal_n = (hold_e == 3'h0);
   assign lock_req_valid = p[5] | p[11];
   assign lock_hits_memory = p[11];
   assign req_addr_valid = p[4] | p[12] | p[13];
   assign last_row_boundary = 36'h0_8000_0000;
   // idle address is the last one and above both limits, so only req_addr_valid keeps it from flagging
   assign req_addr = p[13] ? 36'h1_0000_0000 : p[12] ? 36'h0_C000_0000 : p[4] ? 36'h1_0000_0001 : 36'hF_FFFF_FFFF;
endmodule

// File: test/tb_top.sv
// self-checking bench for the bus error log and report block
`timescale 1ns/100ps
module tb_top
   import err_log_pkg::*;
;
   logic core_clk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
   logic [PADDR_W-1:0] paddr = 12'h000, a;
   logic [DATA_W-1:0]  pwdata = 32'h0, q, prdata;
   logic [3:0]         code = 4'h0;
   logic [15:0]        p;
   logic [SB_ADDR_W-1:0] req_addr, lrb;
   logic pready, pslverr, smi, serr, e, bi_n, be_n, lrv, lhm, rav;
   int n_fail = 0, n_checks = 0, cyc = 0;
   logic [11:0] rows [14] = '{12'h001, 12'h102, 12'h204, 12'h308, 12'h410, 12'h520, 12'h640,
                              12'h780, 12'h840, 12'h910, 12'hA01, 12'hB00, 12'hC00, 12'hD00};
   logic [11:0] regs [6] = '{ADDR_HUB_A_FIRST_ERROR, ADDR_HUB_A_NEXT_ERROR, ADDR_HUB_A_SMI_ENABLE,
                             ADDR_HUB_A_SERR_ENABLE, ADDR_SYS_FIRST_ERROR, ADDR_SYS_NEXT_ERROR};
   logic [7:0] hb [3] = '{8'h40, 8'h10, 8'h01};
   err_source src (.core_clk(core_clk), .fire(fire), .code(code), .p(p), .bus_init_signal_n(bi_n),
      .bus_error_signal_n(be_n), .lock_req_valid(lrv), .lock_hits_memory(lhm), .req_addr_valid(rav),
      .req_addr(req_addr), .last_row_boundary(lrb));
   bus_error_log_and_report dut (.core_clk(core_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .hub_a_target_abort(p[8]), .hub_a_data_parity(p[9]), .hub_a_addr_cmd_parity(p[10]),
      .bus_init_signal_n(bi_n), .bus_error_signal_n(be_n), .lock_req_valid(lrv), .lock_hits_memory(lhm),
      .req_addr_valid(rav), .req_addr(req_addr), .last_row_boundary(lrb), .bus_data_parity_err(p[3]),
      .address_strobe_glitch(p[2]), .data_strobe_glitch(p[1]), .request_parity_err(p[0]), .smi(smi), .serr(serr));
   always #4 core_clk = ~core_clk;
   task results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_fail++;
         results();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] ad, input logic [31:0] x);
      apb(1'b0, ad, 32'h0);
      chk(q, x);
   endtask
   task hit(input logic [3:0] c);
      @(posedge core_clk);
      fire <= 1'b1;
      code <= c;
      @(posedge core_clk);
      fire <= 1'b0;
      // covers the pin synchroniser and edge flop latency
      repeat (10) @(posedge core_clk);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      for (int i = 0; i < 6; i++) rd(regs[i], 32'h0);
      for (int i = 0; i < 14; i++) begin
         hit(rows[i][11:8]);
         a = (rows[i][11:8] inside {[4'h8:4'hA]}) ? ADDR_HUB_A_FIRST_ERROR : ADDR_SYS_FIRST_ERROR;
         rd(a, {24'h0, rows[i][7:0]});
         rd(a + 12'h008, 32'h0);
         apb(1'b1, a, {24'h0, rows[i][7:0]});
         rd(a, 32'h0);
      end
      for (int i = 2; i < 4; i++) begin
         apb(1'b1, regs[i], 32'hFFFF_FFFF);
         rd(regs[i], 32'h51);
         apb(1'b1, regs[i], 32'h0);
         rd(regs[i], 32'h0);
      end
      hit(4'h3);
      hit(4'h1);
      hit(4'h3);
      rd(ADDR_SYS_FIRST_ERROR, 32'h08);
      rd(ADDR_SYS_NEXT_ERROR, 32'h0A);
      apb(1'b1, ADDR_SYS_FIRST_ERROR, 32'h0);
      rd(ADDR_SYS_FIRST_ERROR, 32'h08);
      apb(1'b1, ADDR_SYS_FIRST_ERROR, 32'h08);
      rd(ADDR_SYS_NEXT_ERROR, 32'h0A);
      hit(4'h2);
      rd(ADDR_SYS_FIRST_ERROR, 32'h04);
      apb(1'b1, ADDR_SYS_FIRST_ERROR, 32'hFF);
      apb(1'b1, ADDR_SYS_NEXT_ERROR, 32'hFF);
      rd(ADDR_SYS_NEXT_ERROR, 32'h0);
      for (int j = 0; j < 3; j++) begin
         apb(1'b1, ADDR_HUB_A_SMI_ENABLE, {24'h0, 8'h51 & ~hb[j]});
         hit(4'h8 + 4'(j));
         chk(smi, 1'b0);
         apb(1'b1, ADDR_HUB_A_SMI_ENABLE, {24'h0, hb[j]});
         repeat (3) @(posedge core_clk);
         chk({smi, serr}, 2'b10);
         // only one message type enabled at a time
         apb(1'b1, ADDR_HUB_A_SMI_ENABLE, 32'h0);
         apb(1'b1, ADDR_HUB_A_SERR_ENABLE, {24'h0, hb[j]});
         hit(4'h8 + 4'(j));
         chk({smi, serr}, 2'b01);
         apb(1'b1, ADDR_HUB_A_FIRST_ERROR, {24'h0, hb[j]});
         repeat (3) @(posedge core_clk);
         chk(serr, 1'b1);
         apb(1'b1, ADDR_HUB_A_NEXT_ERROR, {24'h0, hb[j]});
         repeat (3) @(posedge core_clk);
         chk(serr, 1'b0);
         apb(1'b1, ADDR_HUB_A_SERR_ENABLE, 32'h0);
      end
      apb(1'b1, 12'h004, 32'hFF);
      chk(e, 1'b1);
      rd(12'h004, 32'h0);
      chk(e, 1'b1);
      // events while the clock enable is low are lost: the whole bank is frozen
      ce <= 1'b0;
      hit(4'h3);
      ce <= 1'b1;
      rd(ADDR_SYS_FIRST_ERROR, 32'h0);
      apb(1'b1, ADDR_HUB_A_SMI_ENABLE, 32'h51);
      @(posedge core_clk);
      srst <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      rd(ADDR_HUB_A_SMI_ENABLE, 32'h0);
      results();
   end
endmodule
bind bus_error_log_and_report bus_error_log_sva sva (.core_clk(core_clk), .srst(srst), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .hub_a_target_abort(hub_a_target_abort), .hub_a_data_parity(hub_a_data_parity),
   .hub_a_addr_cmd_parity(hub_a_addr_cmd_parity), .smi(smi), .serr(serr));
